// *** wiper_consts.svh ***
// Constants for the dual wiper two-wire target: address pattern,
// instruction fields, reset values and timing counts.
// Assumes a 25 MHz system clock sampling the serial pins.
`ifndef WIPER_CONSTS_SVH
`define WIPER_CONSTS_SVH

// Fixed upper five address bits
`define ADDR_PATTERN        5'h0B
// Instruction byte field positions
`define INSTR_CHANNEL_BIT   7
`define INSTR_RESTORE_BIT   6
`define INSTR_POWER_BIT     5
`define INSTR_OUT1_BIT      4
`define INSTR_OUT2_BIT      3
// Reset values
`define WIPER_MIDSCALE      8'h80
// System clock period in ns and clock-high limit in ns
`define CLOCK_PERIOD_NS     40
`define SCL_HIGH_MAX_NS     50000
`define SCL_HIGH_MAX_CYCLES (`SCL_HIGH_MAX_NS / `CLOCK_PERIOD_NS)

`endif

// *** wiper_pkg.sv ***
// Types shared by the dual wiper two-wire target.
// Assumes the constants header is included by the design files.
package wiper_pkg;

  // Serial engine phases
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_INSTR = 3'b010,
    ST_DATA  = 3'b011,
    ST_READ  = 3'b100,
    ST_ACK   = 3'b101,
    ST_RACK  = 3'b110,
    ST_SKIP  = 3'b111
  } phase_e;

endpackage

// *** pin_sync.sv ***
// Two-flop synchroniser with edge detection on the second stage.
// Assumes the input is asynchronous to clock.
module pin_sync
(
  // System
  input  wire logic clock,
  input  wire logic rst,
  // Pin
  input  wire logic pin_in,
  // Synchronised level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;

  // First stage feeds only the second
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stage1_reg <= 1'b1;
      stage2_reg <= 1'b1;
      stage3_reg <= 1'b1;
    end
    else
    begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Edges seen between stage two and its delayed copy
  assign level = stage2_reg;
  assign rise  = stage2_reg & ~stage3_reg;
  assign fall  = ~stage2_reg & stage3_reg;

endmodule // pin_sync

// *** wiper_target.sv ***
// Dual wiper two-wire target: address, instruction, data write and
// readback, with logic outputs and a power-down state.
// Assumes serial clock and data arrive unsynchronised; an open-drain
// data pin is resolved outside from the output enable.
//
// Contract
// - A write is start, address, instruction, data, each acknowledged, then stop.
// - Only an address of 01011 plus the two select pin levels is answered.
// - The address byte's last bit high means read, low means write.
// - Instruction bit 7 picks channel one at 0 and channel two at 1.
// - Instruction bit 6 high restores the chosen wiper to midscale instead of loading data.
// - Instruction bit 5 high puts the device in power-down, like the pin with opposite sense.
// - Instruction bits 4 and 3 latch onto the two logic outputs until the next instruction.
// - The data byte arrives msb first and loads the chosen wiper.
// - A read returns the wiper last selected by a write instruction.
// - The low-active power-down pin acts three clocks later, with no bus frame, and leaves both wipers unchanged.
// - The two select pins give four distinct addresses.
`include "wiper_consts.svh"

module wiper_target
(
  // System
  input  wire logic       clock,
  input  wire logic       rst,
  // Serial bus
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Address straps and power-down pin
  input  wire logic       address_select_low,
  input  wire logic       address_select_high,
  input  wire logic       power_down_pin_n,
  // Device state
  output logic [7:0]      wiper_register_first,
  output logic [7:0]      wiper_register_second,
  output logic            logic_out_first,
  output logic            logic_out_second,
  output logic            power_down
);

  logic                  scl_level;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  sda_level;
  logic                  sda_rise;
  logic                  sda_fall;
  logic                  start_seen;
  logic                  stop_seen;
  wiper_pkg::phase_e     phase_reg;
  wiper_pkg::phase_e     after_ack_reg;
  logic [7:0]            shift_reg;
  logic [2:0]            count_reg;
  logic                  channel_reg;
  logic                  restore_reg;
  logic                  power_down_request_reg;
  logic                  pin_n_s1_reg;
  logic                  pin_n_s2_reg;
  logic                  ack_drive_reg;
  logic                  nack_reg;
  logic [15:0]           high_count_reg;
  logic [7:0]            shift_next;
  logic                  addr_match;

  // Serial pins pass two flip-flops before any use
  pin_sync u_scl
  (
    .clock  (clock),
    .rst    (rst),
    .pin_in (scl_in),
    .level  (scl_level),
    .rise   (scl_rise),
    .fall   (scl_fall)
  );

  pin_sync u_sda
  (
    .clock  (clock),
    .rst    (rst),
    .pin_in (sda_in),
    .level  (sda_level),
    .rise   (sda_rise),
    .fall   (sda_fall)
  );

  // Start and stop are data edges while clock is high
  assign start_seen = sda_fall & scl_level;
  assign stop_seen  = sda_rise & scl_level;
  assign shift_next = {shift_reg[6:0], sda_level};

  // Address test against fixed pattern and straps
  function automatic logic addr_ok(input logic [7:0] b, input logic hi, input logic lo);
    addr_ok = (b[7:3] == `ADDR_PATTERN) && (b[2] == hi) && (b[1] == lo);
  endfunction

  assign addr_match = addr_ok(shift_next, address_select_high, address_select_low);

  // Clock-high watchdog; a stuck clock drops the frame
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      high_count_reg <= 16'h0000;
    else if (!scl_level || phase_reg == wiper_pkg::ST_IDLE)
      high_count_reg <= 16'h0000;
    else if (high_count_reg != 16'hFFFF)
      high_count_reg <= high_count_reg + 16'h0001;
  end

  // Bit engine: samples on clock rise, moves on clock fall
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      phase_reg     <= wiper_pkg::ST_IDLE;
      after_ack_reg <= wiper_pkg::ST_IDLE;
      shift_reg     <= 8'h00;
      count_reg     <= 3'h0;
      ack_drive_reg <= 1'b0;
      nack_reg      <= 1'b0;
    end
    else if (start_seen)
    begin
      phase_reg     <= wiper_pkg::ST_ADDR;
      count_reg     <= 3'h0;
      ack_drive_reg <= 1'b0;
    end
    else if (stop_seen ||
             high_count_reg > 16'(`SCL_HIGH_MAX_CYCLES))
    begin
      phase_reg     <= wiper_pkg::ST_IDLE;
      ack_drive_reg <= 1'b0;
    end
    else
    begin
      case (phase_reg)
        wiper_pkg::ST_ADDR, wiper_pkg::ST_INSTR, wiper_pkg::ST_DATA:
        begin
          if (scl_rise)
          begin
            shift_reg <= shift_next;
            count_reg <= count_reg + 3'h1;
            if (count_reg == 3'h7)
            begin
              if (phase_reg == wiper_pkg::ST_ADDR && !addr_match)
                phase_reg <= wiper_pkg::ST_SKIP;
              else
              begin
                phase_reg <= wiper_pkg::ST_ACK;
                if (phase_reg == wiper_pkg::ST_ADDR)
                  after_ack_reg <= shift_next[0] ? wiper_pkg::ST_READ
                                                 : wiper_pkg::ST_INSTR;
                else
                  after_ack_reg <= wiper_pkg::ST_DATA;
              end
            end
          end
        end
        wiper_pkg::ST_ACK:
        begin
          // Pull data low from the fall ending the byte to the next fall
          if (scl_fall && !ack_drive_reg)
            ack_drive_reg <= 1'b1;
          else if (scl_fall && ack_drive_reg)
          begin
            ack_drive_reg <= 1'b0;
            phase_reg     <= after_ack_reg;
            count_reg     <= 3'h0;
            if (after_ack_reg == wiper_pkg::ST_READ)
              shift_reg <= channel_reg ? wiper_register_second
                                       : wiper_register_first;
          end
        end
        wiper_pkg::ST_READ:
        begin
          // Next bit is presented after each fall, msb first
          if (scl_fall)
          begin
            if (count_reg == 3'h7)
              phase_reg <= wiper_pkg::ST_RACK;
            else
              shift_reg <= {shift_reg[6:0], 1'b0};
            count_reg <= count_reg + 3'h1;
          end
        end
        wiper_pkg::ST_RACK:
        begin
          // Controller acknowledge: low asks for another copy
          if (scl_rise)
            nack_reg <= sda_level;
          else if (scl_fall)
          begin
            phase_reg <= nack_reg ? wiper_pkg::ST_SKIP : wiper_pkg::ST_READ;
            shift_reg <= channel_reg ? wiper_register_second : wiper_register_first;
            count_reg <= 3'h0;
          end
        end
        wiper_pkg::ST_SKIP, wiper_pkg::ST_IDLE:
          ack_drive_reg <= 1'b0; // Wait for next start
        default:
          phase_reg <= wiper_pkg::ST_IDLE;
      endcase
    end
  end

  // Data pin: open drain, low for acknowledge or a zero read bit
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      sda_oe <= 1'b0;
    else
      sda_oe <= ack_drive_reg |
                (phase_reg == wiper_pkg::ST_READ && !shift_reg[7] && !start_seen
                 && !stop_seen);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      sda_out <= 1'b1;
    else
      sda_out <= 1'b0; // Only ever pulls low; released line floats high
  end

  // Instruction capture at end of its eighth bit
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      channel_reg            <= 1'b0;
      restore_reg            <= 1'b0;
      power_down_request_reg <= 1'b0;
      logic_out_first        <= 1'b0;
      logic_out_second       <= 1'b0;
    end
    else if (phase_reg == wiper_pkg::ST_INSTR && scl_rise && count_reg == 3'h7
             && !start_seen && !stop_seen)
    begin
      channel_reg            <= shift_next[`INSTR_CHANNEL_BIT];
      restore_reg            <= shift_next[`INSTR_RESTORE_BIT];
      power_down_request_reg <= shift_next[`INSTR_POWER_BIT];
      logic_out_first        <= shift_next[`INSTR_OUT1_BIT];
      logic_out_second       <= shift_next[`INSTR_OUT2_BIT];
      // Low three bits are not looked at
    end
  end

  // Wiper update at end of data byte
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wiper_register_first  <= `WIPER_MIDSCALE;
      wiper_register_second <= `WIPER_MIDSCALE;
    end
    else if (phase_reg == wiper_pkg::ST_DATA && scl_rise && count_reg == 3'h7
             && !start_seen && !stop_seen)
    begin
      if (!channel_reg)
        wiper_register_first  <= restore_reg ? `WIPER_MIDSCALE : shift_next;
      else
        wiper_register_second <= restore_reg ? `WIPER_MIDSCALE : shift_next;
    end
  end

  // Power-down pin synchronised; wipers are never touched by it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_n_s1_reg <= 1'b1;
      pin_n_s2_reg <= 1'b1;
    end
    else
    begin
      pin_n_s1_reg <= power_down_pin_n;
      pin_n_s2_reg <= pin_n_s1_reg;
    end
  end

  // Either source forces power-down; the pin path costs three cycles
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      power_down <= 1'b0;
    else
      power_down <= power_down_request_reg | ~pin_n_s2_reg;
  end

endmodule // wiper_target

// *** wiper_target_assertions.sv ***
// Concurrent checks on the ports of the dual wiper target.
// Assumes serial pins held at least three clocks per level.
`include "wiper_consts.svh"
module wiper_target_checker
(
  // System
  input wire logic       clock,
  input wire logic       rst,
  // Serial bus
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Straps and pin
  input wire logic       address_select_low,
  input wire logic       address_select_high,
  input wire logic       power_down_pin_n,
  // Device state
  input wire logic [7:0] wiper_register_first,
  input wire logic [7:0] wiper_register_second,
  input wire logic       logic_out_first,
  input wire logic       logic_out_second,
  input wire logic       power_down
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (rst);

  // Reset state and power-down causes
  a_reset_values:
    assert property ($fell(rst) |-> wiper_register_first == `WIPER_MIDSCALE
      && wiper_register_second == `WIPER_MIDSCALE && !logic_out_first && !logic_out_second)
    else $error("reset values wrong");
  a_pin_forces_down:
    assert property (!power_down_pin_n [*5] |-> power_down)
    else $error("pin low without power-down");
  a_down_has_cause:
    assert property ($rose(power_down) |-> !power_down_pin_n || $past(scl_in, 2))
    else $error("power-down without cause");
  // State moves only on a received byte, so never from the pin
  a_first_on_clock:
    assert property ($changed(wiper_register_first) |-> $past(scl_in, 2))
    else $error("first wiper changed off the serial clock");
  a_second_on_clock:
    assert property ($changed(wiper_register_second) |-> $past(scl_in, 2))
    else $error("second wiper changed off the serial clock");
  a_outs_on_clock:
    assert property ($changed({logic_out_first, logic_out_second}) |-> $past(scl_in, 2))
    else $error("logic outputs changed off the serial clock");
  // Open-drain drive and release after a stop
  a_drive_low_only:
    assert property (sda_oe |-> !sda_out)
    else $error("data driven high");
  a_quiet_after_stop:
    assert property ($rose(sda_in) && scl_in && $past(scl_in) |=> !sda_oe [*4])
    else $error("data driven after stop");

  c_second_write: cover property ($changed(wiper_register_second));
  c_ack_given: cover property ($rose(sda_oe));
  c_pin_down: cover property ($fell(power_down_pin_n));
endmodule // wiper_target_checker

// *** bus_controller_model.sv ***
// Two-wire bus controller model: start, stop and nine-bit slots.
// Assumes a pulled-up data line resolved in the bench.
module bus_controller_model
(
  // System
  input  wire logic clock,
  // Serial bus
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle released; clock stands still between frames
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Start or repeated start: data falls while clock high
  task automatic start_c();
    sda_drv <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b0;
    tick(1);
  endtask

  // Stop: data rises while clock high
  task automatic stop_c();
    sda_drv <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(8);
  endtask

  // Nine slots msb first; clock low five cycles, high three, period unchanged.
  // The target answers four cycles after a fall, so a shorter low phase would
  // move its data edge onto the rise and look like a start.
  task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sda_drv <= tx[i];
      tick(4);
      scl <= 1'b1;
      tick(2);
      rx[i] = sda_line;
      tick(1);
      scl <= 1'b0;
      tick(1);
    end
  endtask
endmodule // bus_controller_model

// *** tb_top.sv ***
// Bench for the dual wiper target: framed writes and reads,
// power-down pin and address decoding.
// Assumes the checker and controller model compile first.
`include "wiper_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       pin_n = 1'b1;
  logic [1:0] strap = 2'b10;
  logic       scl, sda_drv, sda_out, sda_oe, lo1, lo2, pd, rnak;
  logic [7:0] w1, w2, rd, exp_w1;
  logic [2:0] nak;
  logic [8:0] rx;
  int         err_total = 0;
  int         comparisons = 0;
  // Open-drain data line with pull-up
  wire        sda_line = (sda_oe ? sda_out : 1'b1) & sda_drv;

  // 25 MHz clock
  always #20 clock = ~clock;

  wiper_target wiper_target_inst
  (
    .clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_select_low(strap[0]),
    .address_select_high(strap[1]), .power_down_pin_n(pin_n),
    .wiper_register_first(w1), .wiper_register_second(w2),
    .logic_out_first(lo1), .logic_out_second(lo2), .power_down(pd)
  );
  bus_controller_model bus_controller_model_inst
  (
    .clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv)
  );

  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Address, instruction, data; nak holds the three acknowledge slots
  task automatic write_frame(input logic [1:0] sel, input logic [7:0] ins, input logic [7:0] dat);
    bus_controller_model_inst.start_c();
    bus_controller_model_inst.byte_io({`ADDR_PATTERN, sel, 1'b0, 1'b1}, rx);
    nak[2] = rx[0];
    bus_controller_model_inst.byte_io({ins, 1'b1}, rx);
    nak[1] = rx[0];
    bus_controller_model_inst.byte_io({dat, 1'b1}, rx);
    nak[0] = rx[0];
    bus_controller_model_inst.stop_c();
  endtask

  // One byte read back, ended by a nack
  task automatic read_frame();
    bus_controller_model_inst.start_c();
    bus_controller_model_inst.byte_io({`ADDR_PATTERN, strap, 1'b1, 1'b1}, rx);
    rnak = rx[0];
    bus_controller_model_inst.byte_io(9'h1ff, rx);
    rd = rx[8:1];
    bus_controller_model_inst.stop_c();
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Test sequence
  initial
  begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
    cmp_val(w1, `WIPER_MIDSCALE, "first wiper reset");
    cmp_val(w2, `WIPER_MIDSCALE, "second wiper reset");
    cmp_val({6'h00, lo1, lo2}, 8'h00, "outs reset");
    $display("reset test done");
    write_frame(strap, 8'h17, 8'h2d);
    cmp_val({5'h00, nak}, 8'h00, "write acks");
    cmp_val(w1, 8'h2d, "first load");
    cmp_val({5'h00, pd, lo1, lo2}, 8'h02, "outs first");
    write_frame(strap, 8'h88, 8'hc1);
    cmp_val(w2, 8'hc1, "second load");
    cmp_val({5'h00, pd, lo1, lo2}, 8'h01, "outs second");
    read_frame();
    cmp_val({rnak, rd[7:1]}, 8'h60, "readback second");
    cmp_val({7'h00, rd[0]}, 8'h01, "readback lsb");
    cmp_val({5'h00, pd, lo1, lo2}, 8'h01, "outs held");
    $display("write read test done");
    write_frame(strap, 8'h60, 8'h55);
    cmp_val(w1, `WIPER_MIDSCALE, "restore");
    cmp_val({5'h00, pd, lo1, lo2}, 8'h04, "power-down set");
    read_frame();
    cmp_val(rd, `WIPER_MIDSCALE, "readback first");
    write_frame(strap, 8'h80, 8'h07);
    cmp_val({7'h00, pd}, 8'h00, "power-down clear");
    $display("restore test done");
    pin_n <= 1'b0;
    repeat (6) @(posedge clock);
    cmp_val({7'h00, pd}, 8'h01, "pin down");
    cmp_val(w2, 8'h07, "pin keeps wiper");
    pin_n <= 1'b1;
    repeat (6) @(posedge clock);
    cmp_val({7'h00, pd}, 8'h00, "pin up");
    $display("pin test done");
    exp_w1 = `WIPER_MIDSCALE;
    for (int i = 0; i < 4; i++)
    begin
      strap <= 2'(i);
      for (int j = 0; j < 4; j++)
      begin
        write_frame(2'(j), 8'h00, 8'h40 + 8'(4 * i + j));
        if (i == j)
          exp_w1 = 8'h40 + 8'(4 * i + j);
        cmp_val({5'h00, nak}, (i == j) ? 8'h00 : 8'h07, "address acks");
        cmp_val(w1, exp_w1, "address write");
      end
    end
    $display("address test done");
    stop_test();
  end

  // Watchdog well beyond the expected run
  initial
  begin
    repeat (30000) @(posedge clock);
    err_total++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end
endmodule // tb_top

bind wiper_target wiper_target_checker wiper_target_checker_inst
(
  .clock(clock), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .address_select_low(address_select_low),
  .address_select_high(address_select_high), .power_down_pin_n(power_down_pin_n),
  .wiper_register_first(wiper_register_first),
  .wiper_register_second(wiper_register_second), .logic_out_first(logic_out_first),
  .logic_out_second(logic_out_second), .power_down(power_down)
);
